// ---- design/evq_edge_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module evq_edge_sync (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic pin,
  output logic rise
);
  logic s1_q, s2_q, s3_q;

  ////////////////////////////////////////////////////////////
  // two-stage synchroniser, third stage only for the edge
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // s1_q feeds nothing but s2_q, so metastability stays contained
  assign rise = s2_q & ~s3_q;
endmodule
`default_nettype wire

// ---- design/evq_responder.sv ----
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module evq_responder (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [evq_pkg::EVQ_AW-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  input wire logic event_pin,
  input wire logic pps_pin,
  input wire evq_pkg::evq_time_t time_now,
  input wire evq_pkg::evq_pos_t pos_rt,
  input wire evq_pkg::evq_pos_t pos_sv,
  input wire logic [7:0] fix_type,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] pos_mask
);
  import evq_pkg::*;

  typedef enum logic [2:0] {
    R_START, R_ID, R_SUB, R_LENH, R_LENL, R_MODE, R_DATA
  } evq_rx_t;

  logic ev_rise, pps_rise;
  logic [31:0] evcnt_q;
  evq_time_t evt_q;
  logic auto_q;
  logic [3:0] tbase_q, pref_q;
  logic [7:0] smask_q;
  logic wb_ack_q;
  logic [31:0] wb_dat_q;
  evq_rx_t rx_st_q;
  logic [7:0] sub_q, b0_q;
  logic ok_q, dle_q;
  logic [1:0] dcnt_q;
  logic rx_done, ev_req, pos_req;
  logic [7:0] rx_mask, eff_mask;
  logic ev_pend_q, pos_pend_q;
  logic [7:0] pos_mask_q;
  logic busy_q, tx_valid_q, kind_q;
  logic [7:0] tx_data_q, chk_q;
  logic [5:0] idx_q;
  logic [EVQ_BODY_W-1:0] body_q;
  logic ev_take, pos_take, tx_adv, last_byte;
  logic [5:0] blen, nidx;
  logic [7:0] nbyte, chk_d, fix_c;
  logic [15:0] len_c;
  logic [EVQ_EV_W-1:0] ev_body;
  logic [EVQ_BODY_W-1:0] pos_body;
  evq_pos_t psel;
  logic bus_go, wr_go;

  // out-of-range calendar values fall back to the lowest legal value
  function automatic logic [7:0] evq_clamp(input logic [7:0] v,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
    return (v < lo || v > hi) ? lo : v;
  endfunction

  ////////////////////////////////////////////////////////////
  // pins from outside the clock domain
  evq_edge_sync u_ev_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin(event_pin),
    .rise(ev_rise)
  );

  evq_edge_sync u_pps_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin(pps_pin),
    .rise(pps_rise)
  );

  ////////////////////////////////////////////////////////////
  // event capture: count and time stamp move only on a new event
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      evcnt_q <= 32'h0;
      evt_q <= '0;
    end else if (ev_rise) begin
      evcnt_q <= evcnt_q + 32'h1;
      evt_q <= time_now;
    end
  end

  ////////////////////////////////////////////////////////////
  // wishbone classic slave: one wait state, ack for one cycle
  assign bus_go = wb_cyc & wb_stb & ~wb_ack_q;
  // a write lands at the edge where the master sees ack, never earlier
  assign wr_go = wb_cyc & wb_stb & wb_we & wb_ack_q;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h0;
    end else begin
      wb_ack_q <= bus_go;
      if (bus_go && !wb_we) begin
        unique case (wb_adr)
          EVQ_REG_CTRL: wb_dat_q <= {20'h0, pref_q, tbase_q, 3'h0, auto_q};
          EVQ_REG_MASK: wb_dat_q <= {24'h0, smask_q};
          EVQ_REG_EVCNT: wb_dat_q <= evcnt_q;
          EVQ_REG_STAT: wb_dat_q <= {29'h0, pos_pend_q, ev_pend_q, busy_q};
          default: wb_dat_q <= 32'h0; // unmapped reads as zero
        endcase
      end
    end
  end

  // configuration writes, honouring byte lanes
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      auto_q <= 1'b0;
      tbase_q <= EVQ_TB_RST;
      pref_q <= EVQ_PR_RST;
      smask_q <= EVQ_MASK_RST;
    end else if (wr_go) begin
      if (wb_adr == EVQ_REG_CTRL && wb_sel[0]) begin
        auto_q <= wb_dat_w[EVQ_CTRL_AUTO];
        tbase_q <= wb_dat_w[EVQ_CTRL_TB_LSB+:4];
      end
      if (wb_adr == EVQ_REG_CTRL && wb_sel[1]) begin
        pref_q <= wb_dat_w[EVQ_CTRL_PR_LSB+:4];
      end
      if (wb_adr == EVQ_REG_MASK && wb_sel[0]) begin
        smask_q <= wb_dat_w[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // query parser; stuffed 0x10 pairs in the payload count as one byte
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_st_q <= R_START;
      sub_q <= 8'h0;
      b0_q <= 8'h0;
      ok_q <= 1'b0;
      dle_q <= 1'b0;
      dcnt_q <= 2'h0;
    end else if (rx_valid) begin
      unique case (rx_st_q)
        R_START: if (rx_data == EVQ_SOP) rx_st_q <= R_ID;
        R_ID: rx_st_q <= (rx_data == EVQ_PKT_ID) ? R_SUB : R_START;
        R_SUB: begin
          sub_q <= rx_data;
          rx_st_q <= R_LENH;
        end
        R_LENH: rx_st_q <= R_LENL;
        R_LENL: rx_st_q <= R_MODE;
        R_MODE: begin
          ok_q <= (rx_data == EVQ_MODE_QRY);
          dle_q <= 1'b0;
          dcnt_q <= 2'h0;
          rx_st_q <= R_DATA;
        end
        R_DATA: begin
          if (dle_q && rx_data == EVQ_ETX) begin
            dle_q <= 1'b0;
            rx_st_q <= R_START;
          end else if (!dle_q && rx_data == EVQ_SOP) begin
            dle_q <= 1'b1;
          end else begin
            dle_q <= 1'b0;
            if (dcnt_q == 2'h0) b0_q <= rx_data;
            if (dcnt_q != 2'h3) dcnt_q <= dcnt_q + 2'h1;
          end
        end
      endcase
    end
  end

  // a frame ends on 0x10 0x03; checksum is not checked here
  assign rx_done = rx_valid & (rx_st_q == R_DATA) & dle_q & (rx_data == EVQ_ETX) & ok_q;
  assign ev_req = (rx_done & (sub_q == EVQ_SUB_EVT)) | (pps_rise & auto_q);
  assign pos_req = rx_done & (sub_q == EVQ_SUB_POS);
  // one payload byte is just the checksum, so no mask came along
  assign rx_mask = (dcnt_q >= 2'h2) ? b0_q : EVQ_MASK_DEV;
  assign eff_mask = (rx_mask == EVQ_MASK_DEV) ? smask_q : rx_mask;

  ////////////////////////////////////////////////////////////
  // pending requests: a new request wins over the take that clears it
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ev_pend_q <= 1'b0;
      pos_pend_q <= 1'b0;
      pos_mask_q <= EVQ_MASK_RST;
    end else begin
      ev_pend_q <= ev_req | (ev_pend_q & ~ev_take);
      pos_pend_q <= pos_req | (pos_pend_q & ~pos_take);
      if (pos_req) pos_mask_q <= eff_mask;
    end
  end

  ////////////////////////////////////////////////////////////
  // response bodies, snapshotted when a frame starts
  always_comb begin
    psel = pos_mask_q[0] ? pos_sv : pos_rt;
    fix_c = (fix_type > EVQ_FIX_3D) ? EVQ_FIX_NONE : fix_type;
    ev_body = {evcnt_q, evt_q.frac_sec, evt_q.tow, evt_q.week,
               evq_clamp(evt_q.hour, 8'h00, EVQ_HOUR_MAX),
               evq_clamp(evt_q.minute, 8'h00, EVQ_MINSEC_MAX),
               evq_clamp(evt_q.second, 8'h00, EVQ_MINSEC_MAX),
               evq_clamp(evt_q.month, EVQ_CAL_MIN1, EVQ_MONTH_MAX),
               evq_clamp(evt_q.day, EVQ_CAL_MIN1, EVQ_DAY_MAX),
               evt_q.year, {4'h0, tbase_q}, {4'h0, pref_q}};
    // pdop and uncertainties are not served and go out as zero
    pos_body = {pos_mask_q, fix_c, psel.x, psel.y, psel.z,
                psel.ve, psel.vn, psel.vu, 96'h0};
  end

  assign ev_take = ~busy_q & ev_pend_q;
  assign pos_take = ~busy_q & ~ev_pend_q & pos_pend_q;
  assign tx_adv = busy_q & tx_valid_q & tx_ready;
  assign blen = kind_q ? EVQ_POS_BODY : EVQ_EV_BODY;
  assign len_c = kind_q ? EVQ_POS_LEN : EVQ_EV_LEN;
  assign last_byte = (idx_q == blen + 6'h8);

  // next byte of the frame and running checksum over bytes 1..body end
  always_comb begin
    nidx = idx_q + 6'h1;
    chk_d = chk_q;
    if (nidx == 6'h1) begin
      nbyte = EVQ_PKT_ID;
    end else if (nidx == 6'h2) begin
      nbyte = kind_q ? EVQ_SUB_POS : EVQ_SUB_EVT;
    end else if (nidx == 6'h3) begin
      nbyte = len_c[15:8];
    end else if (nidx == 6'h4) begin
      nbyte = len_c[7:0];
    end else if (nidx == 6'h5) begin
      nbyte = EVQ_MODE_RSP;
    end else if (nidx < blen + 6'h6) begin
      nbyte = body_q[EVQ_BODY_W-1-:8];
    end else if (nidx == blen + 6'h6) begin
      nbyte = chk_q;
    end else if (nidx == blen + 6'h7) begin
      nbyte = EVQ_SOP;
    end else begin
      nbyte = EVQ_ETX;
    end
    if (nidx < blen + 6'h6) chk_d = chk_q ^ nbyte;
  end

  ////////////////////////////////////////////////////////////
  // transmitter: event responses go before position responses
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h0;
      idx_q <= 6'h0;
      chk_q <= 8'h0;
      kind_q <= 1'b0;
      body_q <= '0;
    end else if (ev_take || pos_take) begin
      busy_q <= 1'b1;
      tx_valid_q <= 1'b1;
      tx_data_q <= EVQ_SOP;
      idx_q <= 6'h0;
      chk_q <= 8'h0;
      kind_q <= pos_take;
      body_q <= pos_take ? pos_body : {ev_body, {(EVQ_BODY_W - EVQ_EV_W){1'b0}}};
    end else if (tx_adv) begin
      if (last_byte) begin
        busy_q <= 1'b0;
        tx_valid_q <= 1'b0;
      end else begin
        idx_q <= nidx;
        tx_data_q <= nbyte;
        chk_q <= chk_d;
        if (nidx >= 6'h6 && nidx < blen + 6'h6) body_q <= body_q << 8;
      end
    end
  end

  assign wb_ack = wb_ack_q;
  assign wb_dat_r = wb_dat_q;
  assign tx_data = tx_data_q;
  assign tx_valid = tx_valid_q;
  assign pos_mask = pos_mask_q;

  ////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_frame_start;
    ev_take || pos_take;
  endsequence

  sequence s_byte_at(int n);
    busy_q && tx_valid_q && idx_q == n;
  endsequence

  chk_count_hold: assert property (!ev_rise |=> $stable(evcnt_q))
    else $error("event count moved without an event");
  chk_count_step: assert property (ev_rise |=> evcnt_q == $past(evcnt_q) + 32'h1)
    else $error("event count did not step by one");
  chk_frame_start: assert property (s_frame_start |=> tx_valid_q && tx_data_q == EVQ_SOP)
    else $error("frame did not open with start byte");
  chk_frame_tail: assert property (busy_q && tx_valid_q && last_byte |-> tx_data_q == EVQ_ETX)
    else $error("frame did not close with end byte");
  chk_len_field: assert property (s_byte_at(4) |-> tx_data_q == (kind_q ? EVQ_POS_LEN[7:0] : EVQ_EV_LEN[7:0]))
    else $error("length field wrong");
  chk_auto_out: assert property (pps_rise && auto_q |=> ev_pend_q || busy_q)
    else $error("automatic event response not raised");
  chk_mask_default: assert property (pos_req && dcnt_q < 2'h2 |=> pos_mask_q == $past(smask_q))
    else $error("missing mask did not use stored mask");
  chk_mask_echo: assert property ((kind_q and s_byte_at(6)) |-> tx_data_q == pos_mask_q)
    else $error("applied mask not echoed");
  chk_fix_range: assert property ((kind_q and s_byte_at(7)) |-> tx_data_q <= EVQ_FIX_3D)
    else $error("fix type out of range");
  chk_tbase_byte: assert property ((!kind_q and s_byte_at(31)) |-> tx_data_q == {4'h0, tbase_q})
    else $error("time base byte wrong");
endmodule
`default_nettype wire

// ---- inc/evq_pkg.sv ----
`default_nettype none
package evq_pkg;
  // framing bytes
  localparam logic [7:0] EVQ_SOP = 8'h10;
  localparam logic [7:0] EVQ_ETX = 8'h03;
  localparam logic [7:0] EVQ_PKT_ID = 8'ha1;
  localparam logic [7:0] EVQ_SUB_EVT = 8'h06;
  localparam logic [7:0] EVQ_SUB_POS = 8'h11;
  localparam logic [7:0] EVQ_MODE_QRY = 8'h00;
  localparam logic [7:0] EVQ_MODE_RSP = 8'h02;
  localparam logic [7:0] EVQ_MASK_DEV = 8'hff;
  localparam logic [7:0] EVQ_FIX_NONE = 8'h00;
  localparam logic [7:0] EVQ_FIX_3D = 8'h02;
  // calendar bounds
  localparam logic [7:0] EVQ_HOUR_MAX = 8'h17;
  localparam logic [7:0] EVQ_MINSEC_MAX = 8'h3b;
  localparam logic [7:0] EVQ_MONTH_MAX = 8'h0c;
  localparam logic [7:0] EVQ_DAY_MAX = 8'h1f;
  localparam logic [7:0] EVQ_CAL_MIN1 = 8'h01;
  // body sizes in bytes, length fields, and body widths in bits
  localparam logic [5:0] EVQ_EV_BODY = 6'h1b;
  localparam logic [5:0] EVQ_POS_BODY = 6'h32;
  localparam logic [15:0] EVQ_EV_LEN = 16'h001d;
  localparam logic [15:0] EVQ_POS_LEN = 16'h0034;
  localparam int EVQ_BODY_W = 400;
  localparam int EVQ_EV_W = 216;
  // register map
  localparam int EVQ_AW = 8;
  localparam logic [7:0] EVQ_REG_CTRL = 8'h00;
  localparam logic [7:0] EVQ_REG_MASK = 8'h04;
  localparam logic [7:0] EVQ_REG_EVCNT = 8'h08;
  localparam logic [7:0] EVQ_REG_STAT = 8'h0c;
  localparam int EVQ_CTRL_AUTO = 0;
  localparam int EVQ_CTRL_TB_LSB = 4;
  localparam int EVQ_CTRL_PR_LSB = 8;
  localparam logic [3:0] EVQ_TB_RST = 4'h0;
  localparam logic [3:0] EVQ_PR_RST = 4'h0;
  localparam logic [7:0] EVQ_MASK_RST = 8'h00;

  // time of day as kept by the timing core
  typedef struct packed {
    logic [63:0] frac_sec;
    logic [31:0] tow;
    logic [15:0] week;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
    logic [7:0] month;
    logic [7:0] day;
    logic [15:0] year;
  } evq_time_t;

  // position and velocity in the frame the mask asks for
  typedef struct packed {
    logic [63:0] x;
    logic [63:0] y;
    logic [63:0] z;
    logic [31:0] ve;
    logic [31:0] vn;
    logic [31:0] vu;
  } evq_pos_t;
endpackage
`default_nettype wire

// ---- tb/evq_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module evq_host_model (
  input wire logic ref_clk,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic tx_ready
);
  import evq_pkg::*;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  // random back-pressure, so responses see both prompt and slow hosts
  always @(posedge ref_clk) begin
    tx_ready <= ($urandom % 4) != 0;
  end
  // one byte per edge, valid held across the whole packet
  task automatic put(input logic [7:0] v);
    @(posedge ref_clk);
    rx_valid <= 1'b1;
    rx_data <= v;
  endtask
  // query packet; mask bit 2 is never interpreted by this host
  task automatic send(input logic [7:0] sub, input bit has_m, input logic [7:0] m);
    logic [7:0] b[$];
    logic [7:0] c;
    b = '{EVQ_PKT_ID, sub, 8'h00, has_m ? 8'h03 : 8'h02, EVQ_MODE_QRY};
    if (has_m) begin
      b.push_back(m);
    end
    c = 8'h00;
    foreach (b[i]) begin
      c = c ^ b[i];
    end
    b.push_back(c);
    put(EVQ_SOP);
    foreach (b[i]) begin
      put(b[i]);
      if (b[i] == EVQ_SOP) begin
        put(EVQ_SOP); // doubled so it is not mistaken for a delimiter
      end
    end
    put(EVQ_SOP);
    put(EVQ_ETX);
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data; // idle line never repeats the last byte
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import evq_pkg::*;
  logic ref_clk, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack, event_pin, pps_pin;
  logic rx_valid, tx_valid, tx_ready;
  logic [7:0] wb_adr, rx_data, tx_data, pos_mask, fix_type;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r;
  evq_time_t time_now, cap_t;
  evq_pos_t pos_rt, pos_sv;
  logic [7:0] tx_q[$];
  logic [31:0] rd_q[$];
  logic [7:0] qm[4] = '{8'h01, 8'h04, 8'hff, 8'h00};
  int num_errors, n_compared, cycles;
  evq_responder uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .event_pin(event_pin), .pps_pin(pps_pin), .time_now(time_now),
    .pos_rt(pos_rt), .pos_sv(pos_sv), .fix_type(fix_type), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .pos_mask(pos_mask));
  evq_host_model host (.ref_clk(ref_clk), .rx_data(rx_data), .rx_valid(rx_valid), .tx_ready(tx_ready));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // watchers: every result takes the oldest note off its queue
  always @(posedge ref_clk) begin
    if (!sys_rst && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (tx_q.size() == 0) begin
        num_errors++;
        $display("Error tx_data expected none seen %h", tx_data);
      end else begin
        check("tx_data", {24'h0, tx_q.pop_front()}, {24'h0, tx_data});
      end
    end
    if (wb_ack === 1'b1 && wb_we === 1'b0) begin
      check("wb_dat_r", rd_q.pop_front(), wb_dat_r);
    end
  end
  // hang guard sized well above the longest expected run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= 4'hf;
    wb_dat_w <= d;
    // no local limit: only the hang guard ends a wait for ack
    do begin
      @(posedge ref_clk);
    end while (wb_ack !== 1'b1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    wb(a, 1'b0, 32'h0);
  endtask
  // frame = start, body bytes, xor of the body, end pair
  task automatic push_body(input logic [439:0] v, input int n);
    logic [7:0] c;
    c = 8'h00;
    tx_q.push_back(EVQ_SOP);
    for (int i = 0; i < n; i++) begin
      tx_q.push_back(v[8*(n-i)-1 -: 8]);
      c = c ^ v[8*(n-i)-1 -: 8];
    end
    tx_q.push_back(c);
    tx_q.push_back(EVQ_SOP);
    tx_q.push_back(EVQ_ETX);
  endtask
  task automatic exp_ev(input logic [31:0] cnt, input logic [3:0] tb, input logic [3:0] pr);
    push_body(440'({EVQ_PKT_ID, EVQ_SUB_EVT, EVQ_EV_LEN, EVQ_MODE_RSP, cnt, cap_t, 4'h0, tb, 4'h0, pr}),
      32);
  endtask
  task automatic drain();
    int n;
    n = 0;
    while ((tx_q.size() != 0 || tx_valid === 1'b1) && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 3000) begin
      num_errors++;
    end
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic pulse(input bit ev);
    @(posedge ref_clk);
    if (ev) event_pin <= 1'b1;
    else pps_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    event_pin <= 1'b0;
    pps_pin <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask
  // capture one event; a bad calendar comes back at its lowest legal value
  task automatic ev(input logic [31:0] cnt, input bit bad);
    evq_time_t t;
    t = {$urandom, $urandom, $urandom, 16'($urandom), 8'($urandom % 24), 8'($urandom % 60),
      8'($urandom % 60), 8'($urandom % 12 + 1), 8'($urandom % 31 + 1), 16'($urandom % 9000 + 1000)};
    if (bad) t[55:16] = {8'h18, t[47:32], 8'h0d, 8'h00};
    @(posedge ref_clk);
    time_now <= t;
    pulse(1'b1);
    cap_t = t;
    if (bad) cap_t[55:16] = {8'h00, t[47:32], 8'h01, 8'h01};
    exp_ev(cnt, 4'hb, 4'h2);
    host.send(EVQ_SUB_EVT, 1'b0, 8'h00);
    drain();
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {sys_rst, wb_cyc, wb_stb, wb_we, event_pin, pps_pin} = 6'h20;
    {wb_adr, wb_sel, wb_dat_w, fix_type} = '0;
    wb_sel = 4'hf;
    time_now = '0;
    pos_rt = '0;
    pos_sv = '0;
    void'($urandom(95));
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    wb(8'h40, 1'b1, 32'h5a5a5a5a);
    rd(EVQ_REG_CTRL, 32'h0);
    rd(EVQ_REG_MASK, 32'(EVQ_MASK_RST));
    rd(EVQ_REG_EVCNT, 32'h0);
    rd(8'h40, 32'h0);
    rd(EVQ_REG_STAT, 32'h0);
    $display("registers done");
    wb(EVQ_REG_CTRL, 1'b1, 32'hfffff2b0);
    rd(EVQ_REG_CTRL, 32'h000002b0);
    ev(32'h1, 1'b0);
    ev(32'h2, 1'b1);
    rd(EVQ_REG_EVCNT, 32'h2);
    $display("event capture done");
    // every constellation with and without utc; count must not move
    for (int k = 0; k < 8; k++) begin
      wb(EVQ_REG_CTRL, 1'b1, {20'h0, ~k[2], 1'b0, k[1:0], k[2], 1'b0, k[1:0], 4'h0});
      exp_ev(32'h2, {k[2], 1'b0, k[1:0]}, {~k[2], 1'b0, k[1:0]});
      host.send(EVQ_SUB_EVT, 1'b0, 8'h00);
      drain();
    end
    exp_ev(32'h2, 4'h3, 4'hb);
    wb(EVQ_REG_CTRL, 1'b1, 32'h00000b31);
    pulse(1'b0);
    drain();
    wb(EVQ_REG_CTRL, 1'b1, 32'h00000b30);
    pulse(1'b0);
    host.send(8'h22, 1'b0, 8'h00);
    repeat (80) @(posedge ref_clk);
    $display("auto output done");
    // stored mask selects surveyed; 0xff and absent mask both fall back to it
    wb(EVQ_REG_MASK, 1'b1, 32'h00000009);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      pos_rt <= {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      pos_sv <= {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      fix_type <= 8'(i);
      @(posedge ref_clk);
      push_body({EVQ_PKT_ID, EVQ_SUB_POS, EVQ_POS_LEN, EVQ_MODE_RSP, (i >= 2) ? 8'h09 : qm[i],
        (i == 3) ? 8'h00 : fix_type, qm[i][0] | i >= 2 ? pos_sv : pos_rt, 96'h0},
        55);
      host.send(EVQ_SUB_POS, i != 3, qm[i]);
      drain();
      check("pos_mask", (i >= 2) ? 32'h9 : 32'(qm[i]), 32'(pos_mask));
    end
    $display("position done");
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(EVQ_REG_EVCNT, 32'h0);
    $display("second reset done");
    summarize();
  end
endmodule
`default_nettype wire
